/* File: pio_cfg.svh */
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
// Operation
// - Direction 0: driver off, data reads return the synchronised pin level.
// - Direction 1: driver on, data reads return the latched value.
// - Direction bit picks the read source even under peripheral override.
// - An enabled digital peripheral decides pin direction, not the direction bit.
// - Peripheral output pins drive peripheral data, not the port latch.
// - A keypad wake input forces the pin to input.
// - Crystal enabled hands port G bits 5 and 6 to the oscillator.
// - Analog function disables digital pin logic; data bit reads 0.
// - Analog beats digital peripheral when both are enabled.
// - Pullup follows its enable bit, forced off on any output.
// - Pullup is forced off while analog owns the pin.
// - Slew limit bit limits edges; no effect on inputs.
// - Drive select bit 1 gives high drive, 0 gives low drive.
// - Pin control and data/direction registers never alter each other.
// - Partial power-down holds latches; software acknowledges before I/O access.
// - Retained stop keeps all I/O state; resume at once.
// - Data writes latch all but the reserved bits, which stay zero; output pins drive the latch.
// - Reset clears data to zero without driving it.
// - Reset: slew on, low drive, pullup off, input, peripherals off.

// Register select codes on the register port
`define PIO_SEL_DATA 3'h0
`define PIO_SEL_DIR 3'h1
`define PIO_SEL_PULL 3'h2
`define PIO_SEL_SLEW 3'h3
`define PIO_SEL_DRIVE 3'h4
`define PIO_SEL_PWR 3'h5

// Reset values
`define PIO_RST_DATA 8'h00
`define PIO_RST_DIR 8'h00
`define PIO_RST_PULL 8'h00
`define PIO_RST_SLEW 8'hFF
`define PIO_RST_DRIVE 8'h00

// Power control field positions
`define PIO_PWR_FLAG_BIT 0
`define PIO_PWR_ACK_BIT 1

// Port G crystal pin positions
`define PIO_CRYSTAL_OUT_PIN_OUT_BIT 5
`define PIO_CRYSTAL_OUT_PIN_IN_BIT 6

// Port A reserved mask (bits 6..3)
`define PIO_PORTA_RSVD 8'h78
`endif

/* File: pio_pkg.sv */
`default_nettype none
package pio_pkg;
  typedef enum logic [2:0] {
    SEL_DATA = 3'b000,
    SEL_DIR = 3'b001,
    SEL_PULL = 3'b010,
    SEL_SLEW = 3'b011,
    SEL_DRIVE = 3'b100,
    SEL_PWR = 3'b101
  } reg_sel_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_HELD = 2'b01
  } pwr_state_t;
endpackage
`default_nettype wire

/* File: pio_pin_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pio_pin_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] data;
  logic [W-1:0] pull_en;
  logic [W-1:0] slew_en;
  logic [W-1:0] drive_hi;
  logic [W-1:0] periph_en;
  logic [W-1:0] periph_oe;
  logic [W-1:0] periph_out;
  logic [W-1:0] kbd_en;
  logic [W-1:0] analog_en;
  logic [W-1:0] osc_own;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe_n;
  logic [W-1:0] pull_on;
  logic [W-1:0] slew_on;
  logic [W-1:0] drive_on;
  logic [W-1:0] is_out;
  modport mux (input dir, data, pull_en, slew_en, drive_hi, periph_en,
    periph_oe, periph_out, kbd_en, analog_en, osc_own,
    output pin_out, pin_oe_n, pull_on, slew_on, drive_on, is_out);
  modport ctl (output dir, data, pull_en, slew_en, drive_hi, periph_en,
    periph_oe, periph_out, kbd_en, analog_en, osc_own,
    input pin_out, pin_oe_n, pull_on, slew_on, drive_on, is_out);
endinterface
`default_nettype wire

/* File: pio_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module pio_pin_mux #(
  parameter int W = 8
) (
  pio_pin_if.mux p
);
  // ****************************************
  // Per-pin ownership and pad controls
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      logic dig_ok;
      logic out_en;
      // Analog and oscillator both strip all digital control
      assign dig_ok = !p.analog_en[i] && !p.osc_own[i];
      always_comb begin
        if (!dig_ok) begin
          out_en = 1'b0;
        end else if (p.kbd_en[i]) begin
          out_en = 1'b0;
        end else if (p.periph_en[i]) begin
          out_en = p.periph_oe[i];
        end else begin
          out_en = p.dir[i];
        end
      end
      assign p.is_out[i] = out_en;
      assign p.pin_oe_n[i] = !out_en;
      assign p.pin_out[i] = (p.periph_en[i] && !p.kbd_en[i]) ?
        p.periph_out[i] : p.data[i];
      assign p.pull_on[i] = dig_ok && !out_en && p.pull_en[i];
      assign p.slew_on[i] = out_en && p.slew_en[i];
      assign p.drive_on[i] = out_en && p.drive_hi[i];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: pio_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pio_cfg.svh"
module pio_port #(
  parameter int W = 8,
  parameter logic [W-1:0] RSVD_MASK = `PIO_PORTA_RSVD,
  parameter bit HAS_OSC = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [W-1:0] reg_wdata,
  output logic [W-1:0] reg_rdata,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pull_on,
  output logic [W-1:0] slew_on,
  output logic [W-1:0] drive_on,
  input wire logic [W-1:0] periph_en,
  input wire logic [W-1:0] periph_oe,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] kbd_en,
  input wire logic [W-1:0] analog_en,
  input wire logic osc_en,
  input wire logic stop_partial,
  input wire logic stop_retained,
  input wire logic wake_powered,
  output logic io_locked
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [W-1:0] port_data_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] pull_reg;
  logic [W-1:0] slew_reg;
  logic [W-1:0] drive_reg;
  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] rdata_reg;
  logic [W-1:0] rdata_next;
  logic pd_flag_reg;
  pio_pkg::pwr_state_t pwr_reg;
  logic wr_ok;
  logic [W-1:0] osc_mask;

  function automatic logic hit(input logic [2:0] sel, input logic [2:0] code);
    hit = (sel == code);
  endfunction

  // Writes blocked while latches are held after partial power-down
  assign wr_ok = reg_wr && (pwr_reg == pio_pkg::PWR_RUN)
    && !stop_partial;
  assign io_locked = (pwr_reg == pio_pkg::PWR_HELD);

  always_comb begin
    osc_mask = '0;
    if (HAS_OSC && osc_en) begin
      osc_mask[`PIO_CRYSTAL_OUT_PIN_OUT_BIT] = 1'b1;
      osc_mask[`PIO_CRYSTAL_OUT_PIN_IN_BIT] = 1'b1;
    end
  end

  // ****************************************
  // Data and direction group
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_data_reg <= `PIO_RST_DATA;
    end else if (wr_ok && hit(reg_sel, `PIO_SEL_DATA)) begin
      // Reserved bits kept zero in case software slips
      port_data_reg <= reg_wdata & ~RSVD_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_reg <= `PIO_RST_DIR;
    end else if (wr_ok && hit(reg_sel, `PIO_SEL_DIR)) begin
      dir_reg <= reg_wdata & ~RSVD_MASK;
    end
  end

  // ****************************************
  // Pin control group
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pull_reg <= `PIO_RST_PULL;
      slew_reg <= `PIO_RST_SLEW & ~RSVD_MASK;
      drive_reg <= `PIO_RST_DRIVE;
    end else if (wr_ok) begin
      if (hit(reg_sel, `PIO_SEL_PULL)) begin
        pull_reg <= reg_wdata & ~RSVD_MASK;
      end
      if (hit(reg_sel, `PIO_SEL_SLEW)) begin
        slew_reg <= reg_wdata & ~RSVD_MASK;
      end
      if (hit(reg_sel, `PIO_SEL_DRIVE)) begin
        drive_reg <= reg_wdata & ~RSVD_MASK;
      end
    end
  end

  // ****************************************
  // Input synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // Partial power-down handshake
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg <= pio_pkg::PWR_RUN;
      pd_flag_reg <= 1'b0;
    end else begin
      unique case (pwr_reg)
        pio_pkg::PWR_RUN: begin
          if (stop_partial) begin
            pwr_reg <= pio_pkg::PWR_HELD;
            pd_flag_reg <= wake_powered;
          end
        end
        pio_pkg::PWR_HELD: begin
          // Latches hold; only the ack write releases them
          if (stop_partial) begin
            pd_flag_reg <= wake_powered;
          end else if (reg_wr && hit(reg_sel, `PIO_SEL_PWR)
              && reg_wdata[`PIO_PWR_ACK_BIT]) begin
            pwr_reg <= pio_pkg::PWR_RUN;
          end
        end
        default: begin
          pwr_reg <= pio_pkg::PWR_RUN;
        end
      endcase
    end
  end
  // Retained stop needs nothing: stop_retained is ignored; the registers keep their values while the synchroniser keeps sampling
  logic unused_retained;
  assign unused_retained = stop_retained;

  // ****************************************
  // Pin ownership
  // ****************************************
  pio_pin_if #(.W(W)) pif ();
  assign pif.dir = dir_reg;
  assign pif.data = port_data_reg;
  assign pif.pull_en = pull_reg;
  assign pif.slew_en = slew_reg;
  assign pif.drive_hi = drive_reg;
  assign pif.periph_en = periph_en;
  assign pif.periph_oe = periph_oe;
  assign pif.periph_out = periph_out;
  assign pif.kbd_en = kbd_en;
  assign pif.analog_en = analog_en;
  assign pif.osc_own = osc_mask;

  pio_pin_mux #(.W(W)) u_mux (
    .p(pif.mux)
  );

  assign pin_out = pif.pin_out;
  assign pin_oe_n = pif.pin_oe_n;
  assign pull_on = pif.pull_on;
  assign slew_on = pif.slew_on;
  assign drive_on = pif.drive_on;

  // ****************************************
  // Read-back
  // ****************************************
  always_comb begin
    rdata_next = '0;
    if (hit(reg_sel, `PIO_SEL_DATA)) begin
      for (int k = 0; k < W; k++) begin
        if (analog_en[k]) begin
          rdata_next[k] = 1'b0;
        end else if (dir_reg[k]) begin
          rdata_next[k] = port_data_reg[k];
        end else begin
          rdata_next[k] = sync2_reg[k];
        end
      end
      rdata_next = rdata_next & ~RSVD_MASK;
    end else if (hit(reg_sel, `PIO_SEL_DIR)) begin
      rdata_next = dir_reg;
    end else if (hit(reg_sel, `PIO_SEL_PULL)) begin
      rdata_next = pull_reg;
    end else if (hit(reg_sel, `PIO_SEL_SLEW)) begin
      rdata_next = slew_reg;
    end else if (hit(reg_sel, `PIO_SEL_DRIVE)) begin
      rdata_next = drive_reg;
    end else if (hit(reg_sel, `PIO_SEL_PWR)) begin
      rdata_next[`PIO_PWR_FLAG_BIT] = pd_flag_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

/* File: pio_port_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Pin mux and lock checks
// ****
module pio_port_properties #(
  parameter int W = 8,
  parameter logic [W-1:0] RSVD_MASK = 8'h78
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [W-1:0] reg_wdata,
  input wire logic [W-1:0] reg_rdata,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] pull_on,
  input wire logic [W-1:0] slew_on,
  input wire logic [W-1:0] drive_on,
  input wire logic [W-1:0] periph_en,
  input wire logic [W-1:0] periph_oe,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] kbd_en,
  input wire logic [W-1:0] analog_en,
  input wire logic stop_partial,
  input wire logic io_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic [W-1:0] drv = ~pin_oe_n;
  wire logic [W-1:0] pm = periph_en & periph_oe & ~kbd_en & ~analog_en;
  sequence s_dir_wr;
    reg_wr && reg_sel == 3'h1 && !io_locked && !stop_partial;
  endsequence
  sequence s_dir_rd;
    reg_rd && reg_sel == 3'h1;
  endsequence
  property p_an; (analog_en & (drv | pull_on)) == '0; endproperty
  property p_pull; (pull_on & drv) == '0; endproperty
  property p_kbd; (kbd_en & drv) == '0; endproperty
  property p_slew; (slew_on & ~drv) == '0; endproperty
  property p_drive; (drive_on & ~drv) == '0; endproperty
  property p_per;
    ((pin_oe_n | (pin_out ^ periph_out)) & pm & ~RSVD_MASK) == '0;
  endproperty
  property p_lock; stop_partial |=> io_locked; endproperty
  property p_unlock;
    io_locked && !stop_partial && reg_wr && reg_sel == 3'h5 && reg_wdata[1]
      |=> !io_locked;
  endproperty
  property p_rd;
    s_dir_wr ##1 !reg_wr ##1 s_dir_rd
      |=> reg_rdata == ($past(reg_wdata, 3) & ~RSVD_MASK);
  endproperty
  a_an: assert property (p_an) else $error("analog pin still driven");
  a_pull: assert property (p_pull) else $error("pullup on output");
  a_kbd: assert property (p_kbd) else $error("keypad pin driven");
  a_slew: assert property (p_slew) else $error("slew on input");
  a_drive: assert property (p_drive) else $error("drive on input");
  a_per: assert property (p_per) else $error("peripheral not on pin");
  a_lock: assert property (p_lock) else $error("no lock in stop");
  a_unlock: assert property (p_unlock) else $error("ack ignored");
  a_rd: assert property (p_rd) else $error("direction readback");
endmodule
bind pio_port pio_port_properties #(
  .W(W),
  .RSVD_MASK(RSVD_MASK)
) props_inst (
  .clk(clk),
  .arst_n(arst_n),
  .reg_sel(reg_sel),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n),
  .pull_on(pull_on),
  .slew_on(slew_on),
  .drive_on(drive_on),
  .periph_en(periph_en),
  .periph_oe(periph_oe),
  .periph_out(periph_out),
  .kbd_en(kbd_en),
  .analog_en(analog_en),
  .stop_partial(stop_partial),
  .io_locked(io_locked)
);
`default_nettype wire

/* File: pio_board_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Board side of the pins
// ****
module pio_board_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pull_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // Undriven pins wander so a stale level never reads as a match
  logic [7:0] float_reg = 8'h5A;
  always @(posedge clk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pull_on[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule
`default_nettype wire

/* File: parallel_io_pin_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
module parallel_io_pin_control_test;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, osc_en = 0;
  logic stop_partial = 0, stop_retained = 0, wake_powered = 0, io_locked;
  logic [2:0] reg_sel = 3'h0;
  logic [7:0] reg_wdata = 8'h00, periph_en = 8'h00, periph_oe = 8'h00;
  logic [7:0] periph_out = 8'h00, kbd_en = 8'h00, analog_en = 8'h00;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h00, pin_in, reg_rdata, pin_out;
  logic [7:0] pin_oe_n, pull_on, slew_on, drive_on;
  logic [31:0] seed = 32'h8FF51F3C;
  int n_errors = 0, checked = 0, lk = 0, m[6];
  localparam int RS = 8'h78;
  initial forever #25 clk = ~clk;
  pio_port #(.HAS_OSC(1'b1)) pio_port_inst (
    .clk(clk),
    .arst_n(arst_n),
    .reg_sel(reg_sel),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pull_on(pull_on),
    .slew_on(slew_on),
    .drive_on(drive_on),
    .periph_en(periph_en),
    .periph_oe(periph_oe),
    .periph_out(periph_out),
    .kbd_en(kbd_en),
    .analog_en(analog_en),
    .osc_en(osc_en),
    .stop_partial(stop_partial),
    .stop_retained(stop_retained),
    .wake_powered(wake_powered),
    .io_locked(io_locked)
  );
  pio_board_model pio_board_model_inst (
    .clk(clk),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pull_on(pull_on),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pin_in(pin_in)
  );
  // ****
  // Helpers
  // ****
  function automatic int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic chk(string w, int e, logic [7:0] got);
    checked++;
    if (got !== 8'(e)) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", w, 8'(e), got);
    end
  endtask
  task automatic wr(int sel, int v);
    @(posedge clk);
    reg_sel <= 3'(sel);
    reg_wdata <= 8'(v);
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
    if (sel < 5 && lk == 0) m[sel] = v & ~RS;
  endtask
  task automatic rd(int sel, int e, string w, int msk = 255);
    @(posedge clk);
    reg_sel <= 3'(sel);
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(w, e & msk, reg_rdata & 8'(msk));
  endtask
  task automatic pins();
    int pe, oe, po, pin, pu, kn, osc;
    // Crystal takes port G bits 5 and 6
    osc = osc_en ? 8'h60 : 0;
    pe = periph_en & ~kbd_en;
    oe = ~analog_en & ~kbd_en & ~osc & ((pe & periph_oe) | (~pe & m[1]));
    po = (pe & periph_out) | (~pe & m[0]);
    pu = m[2] & ~oe & ~analog_en & ~osc;
    pin = (oe & po) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
    // Undriven, unpulled pins float; their read bits are not compared
    kn = oe | ext_en | pu | m[1] | analog_en;
    // Two sync flops before a pin change is readable
    repeat (3) @(posedge clk);
    #1 chk("oe_n", ~oe, pin_oe_n);
    chk("out", po & oe, pin_out & 8'(oe));
    chk("pull", pu, pull_on);
    chk("slew", m[3] & oe, slew_on);
    chk("drive", m[4] & oe, drive_on);
    rd(0, ~analog_en & ((m[1] & m[0]) | (~m[1] & pin)) & ~RS, "data", kn);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // ****
  // Tests
  // ****
  initial begin
    m = '{0, 0, 0, 8'h87, 0, 0};
    repeat (12) @(posedge clk);
    arst_n <= 1;
    #1 chk("oe_rst", 255, pin_oe_n);
    chk("pull_rst", 0, pull_on);
    rd(0, 0, "data_rst");
    for (int s = 1; s < 5; s++) rd(s, m[s], "reg_rst");
    $display("reset test done");
    repeat (8) begin
      @(posedge clk);
      ext_val <= 8'(rnd());
      ext_en <= 8'(rnd());
      wr(0, rnd() & ~RS);
      wr(1, rnd());
      rd(1, m[1], "dir_reg");
      for (int s = 2; s < 5; s++) wr(s, rnd());
      wr(0, rnd() & ~RS);
      rd(2, m[2], "pull_reg");
      pins();
    end
    $display("port test done");
    repeat (8) begin
      @(posedge clk);
      periph_en <= 8'(rnd() & 8'h87);
      periph_oe <= 8'(rnd());
      periph_out <= 8'(rnd());
      kbd_en <= 8'(rnd() & 8'h87);
      analog_en <= 8'(rnd() & 8'h87);
      wr(1, rnd());
      pins();
    end
    $display("shared function test done");
    @(posedge clk);
    osc_en <= 1;
    periph_en <= 8'h60;
    periph_oe <= 8'h60;
    {kbd_en, analog_en} <= '0;
    @(posedge clk);
    pins();
    $display("crystal test done");
    @(posedge clk);
    {periph_en, kbd_en, analog_en} <= '0;
    osc_en <= 0;
    stop_partial <= 1;
    wake_powered <= 1;
    lk = 1;
    wr(0, 8'h82);
    wr(1, 8'hFF);
    @(posedge clk);
    stop_partial <= 0;
    rd(5, 1, "flag", 1);
    chk("locked", 1, {7'h0, io_locked});
    wr(5, 2);
    lk = 0;
    #1 chk("unlocked", 0, {7'h0, io_locked});
    pins();
    @(posedge clk);
    stop_retained <= 1;
    repeat (3) @(posedge clk);
    stop_retained <= 0;
    pins();
    wr(0, 8'h84);
    pins();
    $display("stop test done");
    conclude();
  end
endmodule
`default_nettype wire
